/* tms_pkg.sv */
// ============================================================
// Purpose: Shared constants and types for the timer sync block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Register structs give the field positions of the control, slave and channel words.
package tms_pkg;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_PRESC = 8'h14;
  localparam logic [7:0] OFS_RELOAD = 8'h18;
  localparam logic [7:0] OFS_CHAN = 8'h1C;
  localparam logic [7:0] OFS_CAPT = 8'h20;
  localparam logic [7:0] OFS_CMP0 = 8'h24;

  // ==========================================================
  // Field positions in words without a struct.
  localparam int EVT_UG_BIT = 0;
  localparam int ST_TRIG_BIT = 0;
  localparam int ST_UPD_BIT = 1;
  localparam int ST_RUN_BIT = 2;

  // ==========================================================
  // Reset values and writable masks.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h0175;
  localparam logic [15:0] SLAVE_RST = 16'h0000;
  localparam logic [15:0] SLAVE_MASK = 16'h7FF7;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;

  // ==========================================================
  // Trigger output selections.
  localparam logic [2:0] MOS_RESET = 3'h0;
  localparam logic [2:0] MOS_ENABLE = 3'h1;
  localparam logic [2:0] MOS_UPDATE = 3'h2;
  localparam logic [2:0] MOS_PULSE = 3'h3;

  // Trigger input selections.
  localparam logic [2:0] TIS_INTERNAL_TRIGGER_ZERO = 3'h0;
  localparam logic [2:0] TIS_TI1_EDGE = 3'h4;
  localparam logic [2:0] TIS_TI1_FILT = 3'h5;
  localparam logic [2:0] TIS_EXT_TRIGGER_FILTERED = 3'h7;

  // Slave mode selections.
  localparam logic [2:0] SMS_OFF = 3'h0;
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIGGER = 3'h6;
  localparam logic [2:0] SMS_EXT1 = 3'h7;

  // ==========================================================
  // Control word: run, update source, output select, alignment.
  typedef struct packed {
    logic [6:0] rsvdHi;
    logic masterSlaveAlign;
    logic rsvd7;
    logic [2:0] masterOutSelect;
    logic rsvd3;
    logic updateSourceSel;
    logic rsvd1;
    logic counterRunBit;
  } tms_ctrl_t;

  // Slave word: mode, trigger input and external trigger path.
  typedef struct packed {
    logic rsvd15;
    logic maskEnable;
    logic extTrigSourceSel;
    logic [1:0] etrFilter;
    logic [1:0] etrPrescale;
    logic etrPolarity;
    logic extClockMode2;
    logic [2:0] triggerInSelect;
    logic rsvd3;
    logic [2:0] slaveModeSelect;
  } tms_slave_t;

  // Channel word: compare polarities and capture conditioning.
  typedef struct packed {
    logic rsvd7;
    logic [1:0] capPrescale;
    logic capPolarity;
    logic [3:0] cmpPolarity;
  } tms_chan_t;

endpackage

/* tms_sync.sv */
// ============================================================
// Purpose: Three-stage resynchroniser with agreement check.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module tms_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Raw and resynchronised levels.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A bit changes only once stages two and three agree on it.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= (stage2 & stage3) | (syncOut & (stage2 ^ stage3));
    end
  end

endmodule

/* tms_timer.sv */
// ============================================================
// Purpose: One timer with master output and slave mode control.
// Assumes: The sibling timer is a second instance of this block.
// Notes: Registers sit on APB with zero wait states.
// Operation
// - Update selection pulses trigger output on update.
// - Selection 000 routes sibling trigger inward.
// - External clock 1 counts trigger rising edges.
// - Compare selections clock the sibling counter.
// - Selection 100 outputs channel 0 reference.
// - Gated mode counts while trigger high.
// - Gating touches only the counter enable.
// - Starting keeps counter and prescaler values.
// - Force update clears counter and prescaler.
// - Counter register is writable for offsets.
// - Trigger mode sets run bit in hardware.
// - Selection 100 takes timer input one.
// - Selection 001 outputs the run signal.
// - Alignment delays prescaler input behind run.
// - One input edge starts both chained timers.
// - Counter clock is the peripheral clock.
// - External trigger source chosen by select.
// - External trigger: polarity, prescale, then filter.
// - Compare out is reference with polarity.
// - Mask pin ANDed with sibling clock pin.
// - Capture input edge, then prescaled capture.
// - Reset mode reinitialises, and raises update when the source bit is low.
// - Trigger flag on rise, both edges gated.
`timescale 1ns/1ps
module tms_timer #(
  parameter int CW = 16,
  parameter int NCH = 4
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the sibling timer and pins.
  input wire logic internalTrigZero,
  input wire logic timerInputOne,
  input wire logic externalClockPin,
  input wire logic otherExternalClockPin,
  input wire logic clockMaskPin,
  output logic triggerOut,
  output logic [NCH-1:0] compareOut
);

  // ==========================================================
  // Resynchronised inputs.
  logic [4:0] syncIn;
  logic itrSync, ti1Sync, clkSync, otherClkSync, maskSync;

  // All outside levels pass one resynchroniser.
  tms_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .asyncIn({internalTrigZero, timerInputOne, externalClockPin,
              otherExternalClockPin, clockMaskPin}),
    .syncOut(syncIn)
  );
  assign {itrSync, ti1Sync, clkSync, otherClkSync, maskSync} = syncIn;

  // ==========================================================
  // Register state.
  tms_pkg::tms_ctrl_t ctrl;
  tms_pkg::tms_slave_t slave;
  tms_pkg::tms_chan_t chan;
  logic [CW-1:0] count, pscCnt, presc, reload, capture;
  logic [CW-1:0] cmp [NCH];
  logic trigFlag, updFlag;

  // APB decode.
  wire setupPh = psel && !penable;
  wire wrEn = psel && penable && pwrite;
  wire hitCtrl = paddr == tms_pkg::OFS_CTRL;
  wire hitSlave = paddr == tms_pkg::OFS_SLAVE;
  wire hitEvent = paddr == tms_pkg::OFS_EVENT;
  wire hitStatus = paddr == tms_pkg::OFS_STATUS;
  wire hitCount = paddr == tms_pkg::OFS_COUNT;
  wire hitPresc = paddr == tms_pkg::OFS_PRESC;
  wire hitReload = paddr == tms_pkg::OFS_RELOAD;
  wire hitChan = paddr == tms_pkg::OFS_CHAN;
  wire hitCapt = paddr == tms_pkg::OFS_CAPT;
  wire [7:0] cmpOfs = paddr - tms_pkg::OFS_CMP0;
  wire hitCmp = (paddr >= tms_pkg::OFS_CMP0) && (cmpOfs[1:0] == 2'b00)
                && (cmpOfs[7:2] < 6'(NCH));
  wire hitAny = hitCtrl || hitSlave || hitEvent || hitStatus || hitCount
                || hitPresc || hitReload || hitChan || hitCapt || hitCmp;
  wire ugWrite = wrEn && hitEvent && pwdata[tms_pkg::EVT_UG_BIT];
  wire cntWrite = wrEn && hitCount;
  wire runClearWr = wrEn && hitCtrl && !pwdata[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;

  // ==========================================================
  // External trigger path.
  logic etrLevel, etrPrev, etrDiv, etrCond, etrFilt, etrFiltPrev;
  logic [2:0] etrEdgeCnt, etrFiltCnt;
  // The mask pin gates the sibling clock pin only when enabled.
  wire maskedOther = otherClkSync & (maskSync | !slave.maskEnable);
  // Source select, then polarity.
  wire etrRaw = slave.extTrigSourceSel ? maskedOther : clkSync;
  wire etrPolar = etrRaw ^ slave.etrPolarity;
  wire etrEdge = etrPolar && !etrPrev;
  wire [2:0] etrHalf = 3'(1 << slave.etrPrescale) >> 1;
  wire [2:0] etrLimit = 3'((1 << slave.etrFilter) - 1);
  assign etrCond = (slave.etrPrescale == 2'b00) ? etrPolar : etrDiv;
  wire etrTick = etrFilt && !etrFiltPrev;

  // Divide the edges, then require the level to hold before use.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      etrPrev <= 1'b0;
      etrDiv <= 1'b0;
      etrEdgeCnt <= 3'h0;
      etrFilt <= 1'b0;
      etrFiltPrev <= 1'b0;
      etrFiltCnt <= 3'h0;
    end else begin
      etrPrev <= etrPolar;
      etrFiltPrev <= etrFilt;
      if (etrEdge && slave.etrPrescale != 2'b00) begin
        if (etrEdgeCnt + 3'h1 >= etrHalf) begin
          etrEdgeCnt <= 3'h0;
          etrDiv <= !etrDiv;
        end else begin
          etrEdgeCnt <= etrEdgeCnt + 3'h1;
        end
      end
      if (etrCond == etrFilt) begin
        etrFiltCnt <= 3'h0;
      end else if (etrFiltCnt >= etrLimit) begin
        etrFilt <= etrCond;
        etrFiltCnt <= 3'h0;
      end else begin
        etrFiltCnt <= etrFiltCnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // Timer input one conditioning and trigger selection.
  logic tiPrev, trigPrev;
  logic [2:0] capEdgeCnt;
  // Polarity applied, then rising edge gives the capture input.
  wire tiFilt = ti1Sync ^ chan.capPolarity;
  wire captureIn = tiFilt && !tiPrev;
  wire [2:0] capLimit = 3'((1 << chan.capPrescale) - 1);
  wire captureScaled = captureIn && (capEdgeCnt >= capLimit);
  wire tiAnyEdge = ti1Sync ^ tiPrev;
  wire [2:0] tsel = slave.triggerInSelect;

  // Sibling trigger on 000, timer input one on 100.
  wire trigLevel = (tsel == tms_pkg::TIS_INTERNAL_TRIGGER_ZERO) ? itrSync
                 : (tsel == tms_pkg::TIS_TI1_EDGE) ? tiAnyEdge
                 : (tsel == tms_pkg::TIS_TI1_FILT) ? tiFilt
                 : (tsel == tms_pkg::TIS_EXT_TRIGGER_FILTERED) ? etrFilt : 1'b0;
  wire trigRise = trigLevel && !trigPrev;
  wire trigFall = !trigLevel && trigPrev;
  wire [2:0] sms = slave.slaveModeSelect;
  wire gated = sms == tms_pkg::SMS_GATED;
  wire resetTrig = (sms == tms_pkg::SMS_RESET) && trigRise;

  // Edge history and capture prescaling.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tiPrev <= 1'b0;
      trigPrev <= 1'b0;
      capEdgeCnt <= 3'h0;
    end else begin
      tiPrev <= tiFilt;
      trigPrev <= trigLevel;
      if (captureScaled) begin
        capEdgeCnt <= 3'h0;
      end else if (captureIn) begin
        capEdgeCnt <= capEdgeCnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // Counter enable and clocking.
  logic pscInDly;
  // Gating acts on the enable only; the count clock stays local.
  wire runSignal = ctrl.counterRunBit && (!gated || trigLevel);
  // Internal ticks come from core_clk itself.
  wire srcTick = (sms == tms_pkg::SMS_EXT1) ? trigRise
               : slave.extClockMode2 ? etrTick : 1'b1;
  wire pscInNow = srcTick && runSignal;
  // With alignment on, the prescaler input lags the run signal.
  wire pscIn = ctrl.masterSlaveAlign ? pscInDly : pscInNow;
  wire pscWrap = pscIn && (pscCnt >= presc);
  wire cntWrap = pscWrap && (count >= reload);
  // Reset mode raises an update only with the source bit low.
  wire updateEvt = cntWrap || ugWrite
                   || (resetTrig && !ctrl.updateSourceSel);
  wire reinit = ugWrite || resetTrig;

  // Counter and prescaler. Starting clears neither.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pscInDly <= 1'b0;
      pscCnt <= '0;
      count <= '0;
    end else begin
      pscInDly <= pscInNow;
      if (reinit) begin
        pscCnt <= '0;
        count <= '0;
      end else if (cntWrite) begin
        count <= pwdata[CW-1:0];
      end else if (pscWrap) begin
        pscCnt <= '0;
        count <= cntWrap ? '0 : count + 1'b1;
      end else if (pscIn) begin
        pscCnt <= pscCnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // Control, slave and channel registers.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= tms_pkg::tms_ctrl_t'(tms_pkg::CTRL_RST);
      slave <= tms_pkg::tms_slave_t'(tms_pkg::SLAVE_RST);
      chan <= tms_pkg::tms_chan_t'(tms_pkg::CHAN_RST);
      presc <= '0;
      reload <= tms_pkg::RELOAD_RST[CW-1:0];
    end else begin
      if (wrEn && hitCtrl) begin
        ctrl <= tms_pkg::tms_ctrl_t'(pwdata[15:0] & tms_pkg::CTRL_MASK);
      end
      // A trigger in trigger mode sets the run bit, winning a clear.
      if ((sms == tms_pkg::SMS_TRIGGER) && trigRise) begin
        ctrl.counterRunBit <= 1'b1;
      end
      if (wrEn && hitSlave) begin
        slave <= tms_pkg::tms_slave_t'(pwdata[15:0] & tms_pkg::SLAVE_MASK);
      end
      if (wrEn && hitChan) begin
        chan <= tms_pkg::tms_chan_t'({1'b0, pwdata[6:0]});
      end
      if (wrEn && hitPresc) begin
        presc <= pwdata[CW-1:0];
      end
      if (wrEn && hitReload) begin
        reload <= pwdata[CW-1:0];
      end
    end
  end

  // Status flags: a hardware set wins over a software clear.
  wire trigEvt = trigRise || (gated && trigFall);
  wire clrTrig = wrEn && hitStatus && pwdata[tms_pkg::ST_TRIG_BIT];
  wire clrUpd = wrEn && hitStatus && pwdata[tms_pkg::ST_UPD_BIT];
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trigFlag <= 1'b0;
      updFlag <= 1'b0;
      capture <= '0;
    end else begin
      trigFlag <= trigEvt || (trigFlag && !clrTrig);
      updFlag <= updateEvt || (updFlag && !clrUpd);
      if (captureScaled) begin
        capture <= count;
      end
    end
  end

  // ==========================================================
  // Compare channels.
  logic [NCH-1:0] cmpRef;
  logic [NCH-1:0] cmpMatch;
  for (genvar i = 0; i < NCH; i++) begin : g_cmp
    // Reference is high while the count is below the compare value.
    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        cmp[i] <= '0;
      end else if (wrEn && hitCmp && cmpOfs[7:2] == 6'(i)) begin
        cmp[i] <= pwdata[CW-1:0];
      end
    end
    assign cmpRef[i] = count < cmp[i];
    assign cmpMatch[i] = pscWrap && (count == cmp[i]);
  end

  // Pin outputs carry the reference with its polarity.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      compareOut <= '0;
    end else begin
      compareOut <= cmpRef ^ chan.cmpPolarity;
    end
  end

  // ==========================================================
  // Master trigger output, registered so the sibling sees clean levels.
  wire [2:0] mos = ctrl.masterOutSelect;
  wire [1:0] refIdx = mos[1:0];
  wire next_triggerOut = (mos == tms_pkg::MOS_RESET) ? ugWrite
    : (mos == tms_pkg::MOS_ENABLE) ? runSignal
    : (mos == tms_pkg::MOS_UPDATE) ? updateEvt
    : (mos == tms_pkg::MOS_PULSE) ? cmpMatch[0]
    : cmpRef[refIdx];
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      triggerOut <= 1'b0;
    end else begin
      triggerOut <= next_triggerOut;
    end
  end

  // ==========================================================
  // Read data, captured in the setup phase.
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCtrl) begin
      rdMux[15:0] = ctrl;
    end else if (hitSlave) begin
      rdMux[15:0] = slave;
    end else if (hitStatus) begin
      rdMux[tms_pkg::ST_TRIG_BIT] = trigFlag;
      rdMux[tms_pkg::ST_UPD_BIT] = updFlag;
      rdMux[tms_pkg::ST_RUN_BIT] = runSignal;
    end else if (hitCount) begin
      rdMux[CW-1:0] = count;
    end else if (hitPresc) begin
      rdMux[CW-1:0] = presc;
    end else if (hitReload) begin
      rdMux[CW-1:0] = reload;
    end else if (hitChan) begin
      rdMux[7:0] = chan;
    end else if (hitCapt) begin
      rdMux[CW-1:0] = capture;
    end else if (hitCmp) begin
      rdMux[CW-1:0] = cmp[cmpOfs[3:2]];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // ==========================================================
  // Checks.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_noWrites;
    !ugWrite && !cntWrite && !resetTrig;
  endsequence

  a_update_trigger_out: assert property (
    (mos == tms_pkg::MOS_UPDATE && updateEvt) |=> triggerOut)
    else $error("Update did not reach trigger output.");
  a_itr_route: assert property (
    (tsel == tms_pkg::TIS_INTERNAL_TRIGGER_ZERO) |-> (trigLevel == itrSync))
    else $error("Sibling trigger not routed inward.");
  a_ext1_tick: assert property (
    (sms == tms_pkg::SMS_EXT1 && runSignal && trigRise
     && !ctrl.masterSlaveAlign) |-> pscIn)
    else $error("Trigger edge did not clock the prescaler.");
  a_idle_hold: assert property (
    (!pscIn ##0 s_noWrites) |=> $stable(count))
    else $error("Counter moved without a tick.");
  a_gate_block: assert property (
    (gated && !trigLevel) |-> !runSignal)
    else $error("Gated counter ran with trigger low.");
  a_trig_start: assert property (
    (sms == tms_pkg::SMS_TRIGGER && trigRise) |=> ctrl.counterRunBit)
    else $error("Trigger did not set the run bit.");
  a_ug_clear: assert property (
    ugWrite |=> (count == '0 && pscCnt == '0))
    else $error("Force update did not clear counter.");
  a_cmp_polar: assert property (
    ##1 compareOut == $past(cmpRef ^ chan.cmpPolarity))
    else $error("Compare output polarity wrong.");
  a_flag_set: assert property (
    trigEvt |=> trigFlag)
    else $error("Trigger flag not set.");
  a_align_lag: assert property (
    (ctrl.masterSlaveAlign && pscInNow) |=> pscIn)
    else $error("Aligned prescaler input not delayed by one.");

endmodule

/* tms_sibling_model.sv */
// ============================================================
// Purpose: Behavioural sibling timer that drives the trigger link.
// Assumes: The link is a plain level registered on core_clk.
// Notes: Pulses are spaced so the receiver's resync sees each one.
`timescale 1ns/1ps
module tms_sibling_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Trigger towards the block under test.
  output logic trigOut
);
  // ==========================================================
  // Link driver.
  // Held low in reset, as a freshly reset sibling would be.
  initial trigOut = 1'b0;

  // Pulses stand two cycles, because the receiver's resync only passes a
  // level once its last two stages agree; one cycle would be lost.
  task automatic pulses(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      trigOut <= 1'b1;
      repeat (2) @(posedge core_clk);
      trigOut <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask

  // A standing level, as an enable or compare selection gives.
  task automatic hold(input logic v);
    @(posedge core_clk);
    trigOut <= v & rst_b;
  endtask
endmodule

/* timer_master_slave_sync_test.sv */
// ============================================================
// Purpose: Self-checking bench for one timer with a sibling model.
// Assumes: APB answers with zero wait states, reset is synchronous.
// Notes: Resync latency is allowed for by settling waits.
`timescale 1ns/1ps
module timer_master_slave_sync_test;
  logic core_clk, rst_b, psel, penable, pwrite, tin, slvErr;
  logic ecp, msk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, itr, triggerOut;
  logic [3:0] compareOut;
  int fail_count = 0;
  int checked = 0;
  int n;

  // ==========================================================
  // Clock, sibling and design.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  tms_sibling_model sib (.core_clk(core_clk), .rst_b(rst_b), .trigOut(itr));
  // Both clock pins share one bench level; the mask pin stays low.
  tms_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internalTrigZero(itr), .timerInputOne(tin), .externalClockPin(ecp),
    .otherExternalClockPin(ecp), .clockMaskPin(msk),
    .triggerOut(triggerOut), .compareOut(compareOut));

  // ==========================================================
  // Bus and check tasks.
  // An idle edge precedes each transfer so no signal is set twice.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    wt(20000);
    fail_count++;
    summarize();
  end

  // ==========================================================
  // Test sequence.
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tin = 1'b0;
    ecp = 1'b0;
    msk = 1'b0;
    wt(8);
    rst_b <= 1'b1;
    wt(4);
    // Reset values and an unmapped place.
    apb(0, tms_pkg::OFS_CTRL, 0);
    chk("ctrl reset", q, 32'h0000_0000);
    apb(0, tms_pkg::OFS_RELOAD, 0);
    chk("reload reset", q, 32'h0000_FFFF);
    apb(0, 8'h40, 0);
    chk("unmapped err", {31'h0, slvErr}, 32'h0000_0001);
    chk("unmapped data", q, 32'h0000_0000);
    $display("test reset done");
    // Preloaded slave clocked by sibling edges.
    apb(1, tms_pkg::OFS_COUNT, 32'h0000_00E7);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("count preload", q, 32'h0000_00E7);
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0007);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0001);
    sib.pulses(5, 6);
    wt(8);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("ext1 count", q, 32'h0000_00EC);
    apb(1, tms_pkg::OFS_EVENT, 32'h0000_0001);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("force update", q, 32'h0000_0000);
    $display("test ext1 done");
    // Gated counting while the sibling level is high.
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0005);
    apb(1, tms_pkg::OFS_STATUS, 32'h0000_0001);
    apb(1, tms_pkg::OFS_EVENT, 32'h0000_0001);
    wt(20);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("gate closed", q, 32'h0000_0000);
    sib.hold(1'b1);
    wt(29);
    sib.hold(1'b0);
    wt(10);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("gate open", {31'h0, q >= 29 && q <= 31}, 1);
    apb(0, tms_pkg::OFS_STATUS, 0);
    chk("gate flag", q & 32'h1, 32'h0000_0001);
    $display("test gated done");
    // Trigger mode sets the run bit from the sibling.
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1, tms_pkg::OFS_STATUS, 32'h0000_0001);
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0006);
    sib.pulses(1, 6);
    apb(0, tms_pkg::OFS_STATUS, 0);
    chk("trig run flag", q & 32'h5, 32'h0000_0005);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0000);
    apb(0, tms_pkg::OFS_STATUS, 0);
    chk("run cleared", q & 32'h4, 32'h0000_0000);
    // Trigger mode from timer input one.
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0046);
    tin <= 1'b1;
    wt(8);
    apb(0, tms_pkg::OFS_CTRL, 0);
    chk("input one run", q & 32'h1, 32'h0000_0001);
    tin <= 1'b0;
    $display("test trigger done");
    // Run signal and update pulses on the trigger output.
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0000);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0011);
    wt(3);
    chk("out run high", {31'h0, triggerOut}, 1);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0010);
    wt(3);
    chk("out run low", {31'h0, triggerOut}, 0);
    apb(1, tms_pkg::OFS_RELOAD, 32'h0000_0003);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0021);
    n = 0;
    while (triggerOut !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (triggerOut !== 1'b1 && n < 50);
    chk("update period", n, 4);
    @(posedge core_clk);
    chk("update pulse", {31'h0, triggerOut}, 0);
    $display("test master done");
    // Compare reference on the output, with and without inversion.
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0040);
    apb(1, tms_pkg::OFS_COUNT, 32'h0000_0005);
    apb(1, tms_pkg::OFS_CMP0, 32'h0000_000A);
    wt(3);
    chk("ref out", {31'h0, triggerOut}, 1);
    chk("cmp out", {31'h0, compareOut[0]}, 1);
    apb(1, tms_pkg::OFS_CHAN, 32'h0000_0001);
    wt(3);
    chk("cmp inverted", {31'h0, compareOut[0]}, 0);
    chk("ref kept", {31'h0, triggerOut}, 1);
    apb(1, tms_pkg::OFS_CMP0, 32'h0000_0003);
    wt(3);
    chk("ref low", {31'h0, triggerOut}, 0);
    $display("test compare done");
    // External clock mode 2 on the own pin, aligned, then masked sibling pin.
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_0080);
    apb(1, tms_pkg::OFS_EVENT, 32'h0000_0001);
    apb(1, tms_pkg::OFS_CTRL, 32'h0000_0101);
    repeat (3) begin
      ecp <= 1'b1;
      wt(4);
      ecp <= 1'b0;
      wt(4);
    end
    wt(6);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("ext2 count", q, 32'h0000_0003);
    apb(1, tms_pkg::OFS_SLAVE, 32'h0000_6080);
    repeat (3) begin
      ecp <= 1'b1;
      wt(4);
      ecp <= 1'b0;
      wt(4);
    end
    wt(6);
    apb(0, tms_pkg::OFS_COUNT, 0);
    chk("masked count", q, 32'h0000_0003);
    $display("test external done");
    summarize();
  end
endmodule
